// [verilog/rsc_rx_status.sv]
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_rx_status import rsc_pkg::*; (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // frame bytes from the mac interface layer
    input  wire logic        i_mil_valid,
    input  wire logic [7:0]  i_mil_data,
    input  wire logic        i_mil_last,
    input  wire logic        i_mil_rx_er,
    input  wire logic        i_mil_crc_bad,
    input  wire logic        i_mil_late_col,
    input  wire logic [2:0]  i_mil_dribble,
    input  wire logic        i_mil_mii_mode,
    input  wire logic        i_mil_filter_fail,
    // receive data fifo side
    input  wire logic        i_dfifo_underrun,
    output logic             o_dfifo_wr,
    output logic      [7:0]  o_dfifo_byte,
    output logic             o_dfifo_commit,
    output logic             o_dfifo_discard,
    output logic             o_dfifo_flush,
    // events
    output logic             o_receive_halted_event,
    output logic             o_receive_error_flag
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    rsc_state_t  state_q;          // receiver sequencer
    logic [31:0] ctrl_q;           // mac control register
    logic [13:0] cnt_q;            // bytes seen this frame
    logic [15:0] lt_q;             // length/type field
    logic        mcast_q;          // first byte group bit
    logic        bcast_q;          // all ff so far
    logic        rxer_q;           // rx error seen
    logic [31:0] word_q;           // status word built
    logic        drop_q;           // frame to be dropped
    logic        err_q;            // sticky error flag
    logic [31:0] mem_q [4];        // status fifo storage
    logic [1:0]  wptr_q;           // fifo write index
    logic [1:0]  rptr_q;           // fifo read index
    logic [2:0]  fcnt_q;           // fifo fill count
    logic        pready_q;         // apb ready
    logic [31:0] prdata_q;         // apb read data
    logic        pslverr_q;        // apb error
    logic        rd_empty_q;       // status read found empty
    logic        halt_ev_q;        // halted pulse
    logic        dwr_q;            // data byte strobe
    logic [7:0]  dbyte_q;          // data byte
    logic        commit_q;         // frame kept
    logic        discard_q;        // frame dropped
    logic        flush_q;          // flush pulse
    logic        receive_enable_bit;             // enable bit
    logic        acc;              // apb transfer completes
    logic        wr_acc;           // completing write
    logic        rd_acc;           // completing read
    logic        push;             // status fifo push
    logic        pop;              // status fifo pop
    logic        ovf;              // push into full fifo
    logic        st_unr;           // status read while empty
    logic        do_flush;         // accepted flush
    logic        start;            // first byte accepted
    logic        in_frame;         // byte belongs to frame
    logic [13:0] len;              // final byte count
    logic        runt;             // frame under 64 bytes
    logic        lenerr;           // length mismatch
    logic [31:0] word_d;           // status word next
    logic        mapped;           // address decodes

    assign receive_enable_bit   = ctrl_q[`RSC_CTRL_RECEIVE_ENABLE_BIT];
    assign acc    = i_psel & i_penable & pready_q;
    assign wr_acc = acc & i_pwrite;
    assign rd_acc = acc & ~i_pwrite;
    assign mapped = (i_paddr == `RSC_OFS_CTRL) |
                    (i_paddr == `RSC_OFS_STAT_PORT) |
                    (i_paddr == `RSC_OFS_INFO) |
                    (i_paddr == `RSC_OFS_FLUSH);
    assign start    = (state_q == RSC_IDLE) & receive_enable_bit & i_mil_valid;
    assign in_frame = start | ((state_q == RSC_FRAME) & i_mil_valid);

    // ----------------------------------------
    // apb slave, one wait state
    // ----------------------------------------
    // ready and read data captured in first access cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pready_q   <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            pslverr_q  <= 1'b0;
            rd_empty_q <= 1'b0;
        end else if (i_psel & i_penable & ~pready_q) begin
            pready_q   <= 1'b1;
            pslverr_q  <= ~mapped;
            rd_empty_q <= (fcnt_q == 3'h0);
            case (i_paddr)
                `RSC_OFS_CTRL: begin
                    prdata_q <= ctrl_q;
                end
                `RSC_OFS_STAT_PORT: begin
                    prdata_q <= (fcnt_q == 3'h0) ? 32'h0000_0000
                                                 : mem_q[rptr_q];
                end
                `RSC_OFS_INFO: begin
                    prdata_q <= {21'h000000, fcnt_q, 6'h00,
                                 state_q == RSC_HALTED, err_q};
                end
                default: begin
                    prdata_q <= 32'h0000_0000;
                end
            endcase
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // control register, only enable and pass bad bits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_q <= `RSC_CTRL_RST;
        end else if (wr_acc && i_paddr == `RSC_OFS_CTRL) begin
            ctrl_q <= i_pwdata & ((32'h1 << `RSC_CTRL_RECEIVE_ENABLE_BIT) |
                                  (32'h1 << `RSC_CTRL_PASS_BAD));
        end
    end

    // ----------------------------------------
    // frame tracking
    // ----------------------------------------
    // byte count, saturating at the field width
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 14'h0000;
        end else if (start) begin
            cnt_q <= 14'h0001;
        end else if (in_frame && cnt_q != 14'h3FFF) begin
            cnt_q <= cnt_q + 14'h0001;
        end
    end

    // address class and length/type capture
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mcast_q <= 1'b0;
            bcast_q <= 1'b0;
            lt_q    <= 16'h0000;
        end else if (start) begin
            mcast_q <= i_mil_data[0];
            bcast_q <= (i_mil_data == 8'hFF);
            lt_q    <= 16'h0000;
        end else if (in_frame) begin
            if (cnt_q < 14'h0006) begin
                bcast_q <= bcast_q & (i_mil_data == 8'hFF);
            end
            if (cnt_q == 14'h000C) begin
                lt_q[15:8] <= i_mil_data;
            end
            if (cnt_q == 14'h000D) begin
                lt_q[7:0] <= i_mil_data;
            end
        end
    end

    // rx error seen at any byte of the frame
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rxer_q <= 1'b0;
        end else if (start) begin
            rxer_q <= i_mil_rx_er;
        end else if (in_frame) begin
            rxer_q <= rxer_q | i_mil_rx_er;
        end
    end

    // ----------------------------------------
    // status word assembly
    // ----------------------------------------
    always_comb begin
        len = (cnt_q == 14'h3FFF || start) ? cnt_q : cnt_q + 14'h0001;
        if (start) begin
            len = 14'h0001;
        end
        runt   = len < `RSC_RUNT_BYTES;
        lenerr = 1'b0;
        if (len >= `RSC_HDR_BYTES && lt_q <= `RSC_TYPE_MIN) begin
            if (lt_q >= `RSC_MIN_PAYLOAD) begin
                lenerr = (lt_q + `RSC_OVERHEAD) != {2'b00, len};
            end else begin
                lenerr = len != `RSC_RUNT_BYTES;
            end
        end
        word_d = 32'h0000_0000;
        word_d[`RSC_ST_FILT] = i_mil_filter_fail;
        word_d[`RSC_ST_LEN_HI:`RSC_ST_LEN_LO] = len;
        word_d[`RSC_ST_BCAST] = bcast_q & (len >= 14'h0006);
        word_d[`RSC_ST_LENERR] = lenerr;
        word_d[`RSC_ST_RUNT] = runt;
        word_d[`RSC_ST_MCAST] = mcast_q;
        word_d[`RSC_ST_LONG] = len > `RSC_LONG_BYTES;
        word_d[`RSC_ST_LATE] = i_mil_late_col;
        word_d[`RSC_ST_TYPE] = (len >= `RSC_HDR_BYTES) &
                               (lt_q > `RSC_TYPE_MIN);
        word_d[`RSC_ST_WDOG] = len > `RSC_WDOG_BYTES;
        word_d[`RSC_ST_MIIERR] = rxer_q | i_mil_rx_er;
        word_d[`RSC_ST_DRIB] = ~i_mil_late_col &
            (i_mil_mii_mode ? (i_mil_dribble == `RSC_DRIB_MII)
                            : (i_mil_dribble >= `RSC_DRIB_10M));
        word_d[`RSC_ST_CRC] = i_mil_crc_bad | rxer_q | i_mil_rx_er;
        word_d[`RSC_ST_ES] = word_d[`RSC_ST_RUNT] | word_d[`RSC_ST_LONG] |
                             word_d[`RSC_ST_LATE] | word_d[`RSC_ST_CRC];
    end

    // ----------------------------------------
    // receiver sequencer
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= RSC_HALTED;
            word_q  <= 32'h0000_0000;
            drop_q  <= 1'b0;
        end else begin
            case (state_q)
                RSC_IDLE: begin
                    if (!receive_enable_bit) begin
                        state_q <= RSC_HALTED;
                    end else if (start && i_mil_last) begin
                        state_q <= RSC_PUSH;
                    end else if (start) begin
                        state_q <= RSC_FRAME;
                    end
                end
                // a frame in progress finishes despite disable
                RSC_FRAME: begin
                    if (i_mil_valid && i_mil_last) begin
                        state_q <= RSC_PUSH;
                    end
                end
                RSC_PUSH: begin
                    state_q <= receive_enable_bit ? RSC_IDLE : RSC_HALTED;
                end
                RSC_HALTED: begin
                    if (receive_enable_bit) begin
                        state_q <= RSC_IDLE;
                    end
                end
                default: begin
                    state_q <= RSC_HALTED;
                end
            endcase
            if (in_frame && i_mil_last) begin
                word_q <= word_d;
                // runt dropped unless passing bad frames
                drop_q <= word_d[`RSC_ST_RUNT] &
                          ~ctrl_q[`RSC_CTRL_PASS_BAD];
            end
        end
    end

    // halted event, one pulse on entry to halted
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            halt_ev_q <= 1'b0;
        end else begin
            halt_ev_q <= (state_q != RSC_HALTED) & ~receive_enable_bit &
                         ((state_q == RSC_IDLE) | (state_q == RSC_PUSH));
        end
    end

    // ----------------------------------------
    // data fifo side
    // ----------------------------------------
    // every byte forwarded, no truncation
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dwr_q     <= 1'b0;
            dbyte_q   <= 8'h00;
            commit_q  <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            dwr_q     <= in_frame;
            dbyte_q   <= in_frame ? i_mil_data : dbyte_q;
            commit_q  <= (state_q == RSC_PUSH) & ~drop_q;
            discard_q <= (state_q == RSC_PUSH) & drop_q;
        end
    end

    // ----------------------------------------
    // status fifo
    // ----------------------------------------
    // push one cycle after the last data byte
    assign push = (state_q == RSC_PUSH) & ~drop_q;
    assign ovf  = push & (fcnt_q == 3'h4) & ~pop;
    assign st_unr = rd_acc & (i_paddr == `RSC_OFS_STAT_PORT) & rd_empty_q;
    assign pop  = rd_acc & (i_paddr == `RSC_OFS_STAT_PORT) &
                  ~rd_empty_q & (fcnt_q != 3'h0);
    assign do_flush = wr_acc & (i_paddr == `RSC_OFS_FLUSH) &
                      i_pwdata[0] & (state_q == RSC_HALTED);

    // one storage entry per index
    for (genvar g = 0; g < 4; g++) begin : g_ent
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                mem_q[g] <= 32'h0000_0000;
            end else if (push && !ovf && wptr_q == 2'(g)) begin
                mem_q[g] <= word_q;
            end
        end
    end

    // pointers and fill count
    always_ff @(posedge i_clk) begin
        if (i_rst || do_flush) begin
            wptr_q <= 2'h0;
            rptr_q <= 2'h0;
            fcnt_q <= 3'h0;
        end else begin
            if (push && !ovf) begin
                wptr_q <= wptr_q + 2'h1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 2'h1;
            end
            fcnt_q <= fcnt_q + {2'b00, push & ~ovf} - {2'b00, pop};
        end
    end

    // flush pulse towards the data fifo
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= do_flush;
        end
    end

    // ----------------------------------------
    // receive error flag
    // ----------------------------------------
    // set wins over a write one to clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            err_q <= 1'b0;
        end else if (i_dfifo_underrun || st_unr || ovf) begin
            err_q <= 1'b1;
        end else if (wr_acc && i_paddr == `RSC_OFS_INFO &&
                     i_pwdata[`RSC_INFO_ERR]) begin
            err_q <= 1'b0;
        end
    end

    assign o_prdata               = prdata_q;
    assign o_pready               = pready_q;
    assign o_pslverr              = pslverr_q;
    assign o_dfifo_wr             = dwr_q;
    assign o_dfifo_byte           = dbyte_q;
    assign o_dfifo_commit         = commit_q;
    assign o_dfifo_discard        = discard_q;
    assign o_dfifo_flush          = flush_q;
    assign o_receive_halted_event = halt_ev_q;
    assign o_receive_error_flag   = err_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    reserved_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        push |-> (word_q[31] | word_q[14] | (|word_q[9:8]) | word_q[0])
                 == 1'b0) else $error("reserved status bit set");
    summary_or_a: assert property (@(posedge i_clk) disable iff (i_rst)
        push |-> word_q[15] == (word_q[11] | word_q[7] | word_q[6] |
                 word_q[1])) else $error("summary bit wrong");
    runt_drop_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (state_q == RSC_PUSH && word_q[11] && !ctrl_q[16]) |=>
        o_dfifo_discard && !o_dfifo_commit) else $error("runt kept");
    type_runt_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (push && word_q[29:16] < 14'd14) |-> !word_q[5])
        else $error("type bit on tiny frame");
    dribble_late_a: assert property (@(posedge i_clk) disable iff (i_rst)
        push |-> !(word_q[2] && word_q[6]))
        else $error("dribble with late collision");
    crc_rxer_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (push && word_q[3]) |-> word_q[1])
        else $error("rx error without crc bit");
    halt_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_receive_halted_event |-> (state_q == RSC_HALTED) ##1
        !o_receive_halted_event) else $error("halt pulse wrong");
    flush_halted_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_dfifo_flush |-> $past(state_q) == RSC_HALTED && fcnt_q == 3'h0)
        else $error("flush outside halt");
    error_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_dfifo_underrun || ovf || st_unr) |=> o_receive_error_flag)
        else $error("error flag missed");
    keep_going_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_receive_error_flag && state_q == RSC_IDLE && receive_enable_bit &&
         i_mil_valid && !i_mil_last) |=> state_q == RSC_FRAME)
        else $error("receiver stopped on error");
    push_after_data_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (in_frame && i_mil_last) |=> (state_q == RSC_PUSH) && o_dfifo_wr)
        else $error("status before data");

endmodule // rsc_rx_status

// [shared/rsc_defs.svh]
// Overview of operation
// - reserved status bits always read zero
// - bit 30 flags address filter failure
// - bits 29:16 carry frame byte count
// - bit 15 ORs runt, long, late, crc
// - bit 13 flags broadcast destination
// - bit 12 flags length field mismatch
// - runt under 64, passed only if allowed
// - bit 10 flags multicast destination
// - bit 7 over 1518, never truncated
// - bit 6 flags late collision
// - bit 5 type over 1500, not tiny runts
// - bit 4 flags receive watchdog expiry
// - bit 3 flags rx error seen
// - bit 2 dribble rules, not with collision
// - bit 1 crc mismatch or rx error
// - one pulse when receiver really halts
// - flush of fifos accepted while halted
// - error flag on underruns or overflow
// - reception continues after error flag
// - status pushed after frame data written
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH
// register byte offsets
`define RSC_OFS_CTRL      12'h000
`define RSC_OFS_STAT_PORT 12'h004
`define RSC_OFS_INFO      12'h008
`define RSC_OFS_FLUSH     12'h00C
// control register fields
`define RSC_CTRL_RECEIVE_ENABLE_BIT     1
`define RSC_CTRL_PASS_BAD 16
`define RSC_CTRL_RST      32'h0000_0000
// info register fields
`define RSC_INFO_ERR      0
`define RSC_INFO_HALTED   1
`define RSC_INFO_CNT_LO   8
// status word positions
`define RSC_ST_FILT       30
`define RSC_ST_LEN_HI     29
`define RSC_ST_LEN_LO     16
`define RSC_ST_ES         15
`define RSC_ST_BCAST      13
`define RSC_ST_LENERR     12
`define RSC_ST_RUNT       11
`define RSC_ST_MCAST      10
`define RSC_ST_LONG       7
`define RSC_ST_LATE       6
`define RSC_ST_TYPE       5
`define RSC_ST_WDOG       4
`define RSC_ST_MIIERR     3
`define RSC_ST_DRIB       2
`define RSC_ST_CRC        1
// frame size figures in bytes
`define RSC_RUNT_BYTES    14'd64
`define RSC_LONG_BYTES    14'd1518
`define RSC_TYPE_MIN      16'd1500
`define RSC_HDR_BYTES     14'd14
`define RSC_WDOG_BYTES    14'd2048
`define RSC_OVERHEAD      16'd18
`define RSC_MIN_PAYLOAD   16'd46
// dribble bit thresholds
`define RSC_DRIB_MII      3'd4
`define RSC_DRIB_10M      3'd3
`endif

// [shared/rsc_pkg.sv]
package rsc_pkg;
    // receiver sequencing states
    typedef enum logic [1:0] {
        RSC_IDLE,
        RSC_FRAME,
        RSC_PUSH,
        RSC_HALTED
    } rsc_state_t;
endpackage

// [verif/rsc_dfifo_model.sv]
`timescale 1ns/1ps
module rsc_dfifo_model (
    input  wire logic i_clk,      // bench clock
    input  wire logic i_rst,      // sync reset
    input  wire logic i_wr,       // byte stored
    input  wire logic i_discard,  // frame dropped
    input  wire logic i_flush,    // flush accepted
    input  wire logic i_kick,     // host underread
    output logic      o_underrun, // underrun pulse
    output int        o_n_wr,     // bytes stored
    output int        o_n_discard,// frames dropped
    output int        o_n_flush   // flushes seen
);
    // ----------------------------------------
    // data fifo bookkeeping
    // ----------------------------------------
    // stores and flushes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_n_wr      <= 0;
            o_n_discard <= 0;
            o_n_flush   <= 0;
        end else begin
            o_n_wr      <= o_n_wr + 32'(i_wr);
            o_n_discard <= o_n_discard + 32'(i_discard);
            o_n_flush   <= o_n_flush + 32'(i_flush);
        end
    end
    always_ff @(posedge i_clk) begin
        o_underrun <= i_rst ? 1'h0 : i_kick;
    end
endmodule  // rsc_dfifo_model

// [verif/test_rsc_rx_status.sv]
`timescale 1ns/1ps
module test_rsc_rx_status;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        i_clk = 1'h0, i_rst = 1'h1;      // clock, reset
    logic        psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic [11:0] paddr = 12'h000;                 // apb address
    logic [31:0] pwdata = 32'h0, prdata, rdat;    // apb data
    logic        pready, pslverr, rerr;           // apb answer
    logic        mv = 1'h0, ml = 1'h0, rxer = 1'h0, crcb = 1'h0;
    logic        late = 1'h0, mii = 1'h0, filt = 1'h0, kick = 1'h0;
    logic [7:0]  md = 8'h00;                      // frame byte
    logic [2:0]  drib = 3'h0;                     // dribble bits
    logic        dwr, ddis, dfl, und, halt, err;  // observed
    int          nwr, ndis, nfl, nhalt = 0;       // event counts
    logic        cm;                              // frame kept pulse
    logic [7:0]  db, lastb;                       // forwarded bytes
    int          ncm = 0;                         // frames kept
    int          n_mismatch = 0, n_tests = 0;     // verdict counts

    always #4 i_clk = ~i_clk;  // 8 ns period
    always @(posedge i_clk) if (halt === 1'h1) nhalt <= nhalt + 1;
    always @(posedge i_clk) if (cm === 1'h1) ncm <= ncm + 1;
    always @(posedge i_clk) if (dwr === 1'h1) lastb <= db;

    rsc_rx_status u_rsc_rx_status (.i_clk(i_clk), .i_rst(i_rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_mil_valid(mv), .i_mil_data(md),
        .i_mil_last(ml), .i_mil_rx_er(rxer), .i_mil_crc_bad(crcb),
        .i_mil_late_col(late), .i_mil_dribble(drib),
        .i_mil_mii_mode(mii), .i_mil_filter_fail(filt),
        .i_dfifo_underrun(und), .o_dfifo_wr(dwr), .o_dfifo_byte(db),
        .o_dfifo_commit(cm), .o_dfifo_discard(ddis), .o_dfifo_flush(dfl),
        .o_receive_halted_event(halt), .o_receive_error_flag(err));
    rsc_dfifo_model u_rsc_dfifo_model (.i_clk(i_clk), .i_rst(i_rst),
        .i_wr(dwr), .i_discard(ddis), .i_flush(dfl), .i_kick(kick),
        .o_underrun(und), .o_n_wr(nwr), .o_n_discard(ndis),
        .o_n_flush(nfl));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge i_clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'h1;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (k >= 20) n_mismatch++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask

    // one frame, flags given with the last byte
    task automatic frame(input int n, input logic [7:0] dst,
                         input logic [15:0] lt, input logic [7:0] f);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            mv <= 1'h1;
            ml <= (i == n - 1);
            md <= i < 6 ? dst : i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : 8'(i);
            {drib, filt, mii, late, crcb, rxer} <= (i == n - 1) ? f : 8'h00;
        end
        @(posedge i_clk);
        mv <= 1'h0;
        ml <= 1'h0;
        {drib, filt, mii, late, crcb, rxer} <= 8'h00;
        repeat (4) @(posedge i_clk);
    endtask

    // frame, then its status word from the port
    task automatic fchk(input int n, input logic [7:0] dst,
                        input logic [15:0] lt, input logic [7:0] f,
                        input logic [31:0] exp);
        int w0;
        int c0;
        w0 = nwr;
        c0 = ncm;
        frame(n, dst, lt, f);
        check(32'(nwr - w0), 32'(n));
        check(32'(ncm - c0), 32'h1);
        check(32'(lastb), 32'(n > 14 ? 8'(n - 1) : lt[15:8]));
        apb(1'h0, 12'h004, 32'h0);
        check(rdat, exp);
    endtask

    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        conclude();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        int d0;
        repeat (10) @(posedge i_clk);
        i_rst <= 1'h0;
        apb(1'h0, 12'h000, 32'h0);
        check(rdat, 32'h0);
        apb(1'h0, 12'h008, 32'h0);
        check(rdat, 32'h2);
        apb(1'h0, 12'h010, 32'h0);
        check({rdat[30:0], rerr}, 32'h1);
        apb(1'h1, 12'h000, 32'h0001_0002);
        fchk(64, 8'h01, 16'h0800, 8'h00, 32'h0040_0420);
        fchk(64, 8'hFF, 16'h0800, 8'h00, 32'h0040_2420);
        fchk(1519, 8'h02, 16'h0800, 8'h02, 32'h05EF_80A2);
        fchk(2049, 8'h02, 16'h0800, 8'h00, 32'h0801_80B0);
        fchk(20, 8'h02, 16'h0800, 8'h00, 32'h0014_8820);
        fchk(13, 8'h02, 16'h0800, 8'h00, 32'h000D_8800);
        fchk(64, 8'h02, 16'h0040, 8'h01, 32'h0040_900A);
        fchk(64, 8'h02, 16'h002E, 8'h8C, 32'h0040_8040);
        fchk(64, 8'h02, 16'h002E, 8'h98, 32'h4040_0004);
        fchk(64, 8'h02, 16'h002E, 8'h60, 32'h0040_0004);
        fchk(64, 8'h02, 16'h002E, 8'h68, 32'h0040_0000);
        apb(1'h1, 12'h000, 32'h2);
        d0 = ndis;
        frame(20, 8'h02, 16'h0800, 8'h00);
        check(32'(ndis - d0), 32'h1);
        apb(1'h0, 12'h008, 32'h0);
        check(rdat, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        check(rdat, 32'h0);
        apb(1'h0, 12'h008, 32'h0);
        check(rdat, 32'h1);
        apb(1'h1, 12'h008, 32'h1);
        apb(1'h0, 12'h008, 32'h0);
        check(rdat, 32'h0);
        @(posedge i_clk);
        kick <= 1'h1;
        @(posedge i_clk);
        kick <= 1'h0;
        apb(1'h0, 12'h008, 32'h0);
        check(rdat, 32'h1);
        check(32'(err), 32'h1);
        fchk(64, 8'h02, 16'h002E, 8'h00, 32'h0040_0000);
        apb(1'h1, 12'h008, 32'h1);
        @(posedge i_clk);
        i_rst <= 1'h1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'h0;
        apb(1'h0, 12'h008, 32'h0);
        check(rdat, 32'h2);
        check(32'(err), 32'h0);
        apb(1'h1, 12'h000, 32'h2);
        frame(64, 8'h02, 16'h002E, 8'h00);
        apb(1'h1, 12'h000, 32'h0);
        repeat (4) @(posedge i_clk);
        check(32'(nhalt), 32'h1);
        apb(1'h0, 12'h008, 32'h0);
        check(rdat, 32'h102);
        apb(1'h1, 12'h00C, 32'h1);
        apb(1'h0, 12'h008, 32'h0);
        check(rdat, 32'h2);
        check(32'(nfl), 32'h1);
        apb(1'h1, 12'h000, 32'h2);
        fchk(64, 8'h01, 16'h0800, 8'h00, 32'h0040_0420);
        conclude();
    end
endmodule  // test_rsc_rx_status
